// [src/pdmm_map.v]
`timescale 1ns/1ns
`include "pdmm_regs.vh"
module pdmm_map #(
	parameter LARGE = 0
) (
	input  wire        clk,
	input  wire        resetn,
	input  wire        ce,
	input  wire        pc_load,
	input  wire [12:0] pc_load_val,
	input  wire        pc_inc,
	input  wire        irq_take,
	output reg  [12:0] pc_r,
	output wire [10:0] prog_addr,
	input  wire [6:0]  file_addr,
	input  wire        data_rd,
	input  wire        data_we,
	input  wire [7:0]  data_wdata,
	output wire [7:0]  data_rdata,
	output wire        sfr_sel,
	output wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_rdata,
	output reg  [7:0]  status_r,
	output reg  [7:0]  file_select_pointer_r
);
	localparam PLG = LARGE ? `PDMM_LARGE_DEPTH_LG : `PDMM_SMALL_DEPTH_LG;
	localparam RAM_AW = LARGE ? 7 : 6;

	// ****************************************************************
	// Program counter.
	// ****************************************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_r <= `PDMM_RESET_VECTOR;
		end else if (ce) begin
			if (irq_take) begin
				pc_r <= `PDMM_IRQ_VECTOR;
			end else if (pc_load) begin
				pc_r <= pc_load_val;
			end else if (pc_inc) begin
				pc_r <= pc_r + 13'h0001;
			end
		end
	end

	// ****************************************************************
	// Program memory address.
	// ****************************************************************
	// The mask keeps only the implemented address bits, so fetches wrap.
	localparam [10:0] PROG_MASK = (11'h001 << PLG) - 11'h001;

	assign prog_addr = pc_r[10:0] & PROG_MASK;

	// ****************************************************************
	// Data address formation.
	// ****************************************************************
	wire       bank_select_bit     = status_r[`PDMM_STAT_BANK_BIT];
	wire       upper_bank_bit      = status_r[`PDMM_STAT_UPPER_BIT];
	wire       indirect_bank_bit   = status_r[`PDMM_STAT_IND_BIT];
	wire       indirect_access_location = (file_addr == `PDMM_INDIRECT_LOC);
	wire [7:0] direct_addr = {bank_select_bit, file_addr};

	// ****************************************************************
	// Effective address.
	// ****************************************************************
	// The indirect location uses the whole pointer, so both banks are reached.
	wire [7:0] eff_addr;

	assign eff_addr = indirect_access_location ?
		file_select_pointer_r : direct_addr;

	// ****************************************************************
	// Implemented location decode.
	// ****************************************************************
	// Decodes a full 8-bit location into an implemented flag in the top bit.
	function [7:0] ram_map;
		input [7:0] a;
		begin
			ram_map = 8'h00;
			if (a[6:0] <= `PDMM_SFR_TOP) begin
				ram_map = 8'h00;
			end else if (a[6:0] >= `PDMM_MIRROR_LO) begin
				ram_map = {1'b1, 1'b0, a[5:0]};
			end else if (!a[7] && LARGE != 0) begin
				ram_map = {1'b1, 1'b0, a[5:0]};
			end else if (!a[7] && a[6:0] >= `PDMM_SMALL_GPR_LO) begin
				ram_map = {1'b1, 1'b0, a[5:0]};
			end else if (a[7] && LARGE != 0 && a[6:0] >= `PDMM_B1_GPR_LO
				&& a[6:0] <= `PDMM_B1_GPR_HI) begin
				ram_map = {1'b1, 1'b1, 1'b0, a[4:0]};
			end
		end
	endfunction

	// ****************************************************************
	// Storage index.
	// ****************************************************************
	// Bank 0 20h-7Fh take indices 00h-5Fh; bank 1 A0h-EFh take 60h-AFh mod 128.
	// The small variant keeps only the low six address bits.
	function [6:0] ram_index;
		input [7:0] a;
		begin
			ram_index = {1'b0, a[5:0]};
			if (LARGE != 0) begin
				if (a[6:0] >= `PDMM_MIRROR_LO) begin
					ram_index = a[6:0] - 7'h20;
				end else if (!a[7]) begin
					ram_index = a[6:0] - 7'h20;
				end else begin
					ram_index = a[6:0] + 7'h40;
				end
			end
		end
	endfunction

	// Tells whether a location names a given core register in either bank.
	function core_loc;
		input [7:0] a;
		input [6:0] loc;
		begin
			core_loc = (a[6:0] == loc);
		end
	endfunction

	// ****************************************************************
	// Location classes.
	// ****************************************************************
	wire [7:0] map_v   = ram_map(eff_addr);
	wire       ram_hit = map_v[7];
	wire [6:0] ram_idx = ram_index(eff_addr);
	wire       sfr_hit = (eff_addr[6:0] <= `PDMM_SFR_TOP) &&
		!(indirect_access_location && eff_addr[6:0] == `PDMM_INDIRECT_LOC);
	wire       is_status = sfr_hit && core_loc(eff_addr, `PDMM_STATUS_LOC);
	wire       is_fsp    = sfr_hit && core_loc(eff_addr, `PDMM_FSP_LOC);
	wire [7:0] ram_rdata;

	// ****************************************************************
	// General-purpose storage.
	// ****************************************************************
	pdmm_gpr #(
		.AW (RAM_AW)
	) u_gpr (
		.clk   (clk),
		.ce    (ce),
		.we    (data_we && ram_hit),
		.waddr (ram_idx[RAM_AW-1:0]),
		.wdata (data_wdata),
		.raddr (ram_idx[RAM_AW-1:0]),
		.rdata (ram_rdata)
	);

	// ****************************************************************
	// Core status and pointer registers.
	// ****************************************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_r              <= `PDMM_STATUS_RESET;
			file_select_pointer_r <= `PDMM_FSP_RESET;
		end else if (ce && data_we) begin
			if (is_status) begin
				status_r <= data_wdata;
			end
			if (is_fsp) begin
				file_select_pointer_r <= data_wdata;
			end
		end
	end

	// ****************************************************************
	// External special register port.
	// ****************************************************************
	// Status and pointer live here, so only the other special registers go out.
	wire       sfr_access = data_rd || data_we;
	wire       sfr_ext    = sfr_hit && !is_status && !is_fsp;

	assign sfr_sel  = sfr_ext && sfr_access;
	assign sfr_addr = eff_addr;

	// ****************************************************************
	// Reserved status bits.
	// ****************************************************************
	// Reserved bank bits take part in no decode.
	wire unused_bits = upper_bank_bit | indirect_bank_bit;

	// ****************************************************************
	// Read data selection.
	// ****************************************************************
	reg  [7:0] rdata_mux;

	always @* begin
		rdata_mux = 8'h00;
		if (is_status) begin
			rdata_mux = status_r;
		end else if (is_fsp) begin
			rdata_mux = file_select_pointer_r;
		end else if (sfr_hit) begin
			rdata_mux = sfr_rdata;
		end else if (ram_hit) begin
			rdata_mux = ram_rdata;
		end
	end

	assign data_rdata = rdata_mux;
endmodule

// [src/pdmm_regs.vh]
`ifndef PDMM_REGS_VH
`define PDMM_REGS_VH
`define PDMM_PC_W           13
`define PDMM_INSN_W         14
`define PDMM_RESET_VECTOR   13'h0000
`define PDMM_IRQ_VECTOR     13'h0004
`define PDMM_SMALL_DEPTH_LG 10
`define PDMM_LARGE_DEPTH_LG 11
`define PDMM_SFR_TOP        7'h1f
`define PDMM_SMALL_GPR_LO   7'h40
`define PDMM_LARGE_GPR_LO   7'h20
`define PDMM_B1_GPR_LO      7'h20
`define PDMM_B1_GPR_HI      7'h6f
`define PDMM_MIRROR_LO      7'h70
`define PDMM_INDIRECT_LOC   7'h00
`define PDMM_STATUS_LOC     7'h03
`define PDMM_FSP_LOC        7'h04
`define PDMM_STAT_BANK_BIT  5
`define PDMM_STAT_UPPER_BIT 6
`define PDMM_STAT_IND_BIT   7
`define PDMM_STATUS_RESET   8'h18
`define PDMM_FSP_RESET      8'h00
`endif

// [src/pdmm_gpr.v]
`timescale 1ns/1ns
`include "pdmm_regs.vh"
module pdmm_gpr #(
	parameter AW = 7
) (
	input  wire          clk,
	input  wire          ce,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [7:0]    wdata,
	input  wire [AW-1:0] raddr,
	output wire [7:0]    rdata
);
	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule

// [tb/pdmm_map_sva.sv]
`timescale 1ns/1ns
// ****
// Checker.
// ****
module pdmm_map_sva #(
	parameter LARGE = 0
) (
	input wire        clk,
	input wire        resetn,
	input wire        ce,
	input wire        irq_take,
	input wire        data_we,
	input wire [12:0] pc_r,
	input wire [10:0] prog_addr,
	input wire [6:0]  file_addr,
	input wire [7:0]  data_rdata,
	input wire [7:0]  sfr_addr,
	input wire [7:0]  status_r,
	input wire [7:0]  file_select_pointer_r
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
a_reset_vector: assert property ($rose(resetn) |-> pc_r == 13'h0000) else $error("pc");
a_irq_vector: assert property (ce && irq_take |=> pc_r == 13'h0004) else $error("irq");
a_irq_fetch: assert property (ce && irq_take |=> prog_addr == 11'h004) else $error("fetch");
a_prog_wrap: assert property (prog_addr == (LARGE ? pc_r[10:0] : {1'b0, pc_r[9:0]}))
	else $error("wrap");
a_direct_map: assert property (file_addr != 7'h00 |-> sfr_addr == {status_r[5], file_addr})
	else $error("direct");
a_indirect_map: assert property (file_addr == 7'h00 |-> sfr_addr == file_select_pointer_r)
	else $error("indirect");
a_unimpl_zero: assert property (!LARGE && sfr_addr[6:5] == 2'b01 |-> data_rdata == 8'h00)
	else $error("unimpl");
a_bank_hold: assert property (!(data_we && sfr_addr[6:0] == 7'h03) |=> $stable(status_r[5]))
	else $error("bank");
endmodule
bind pdmm_map pdmm_map_sva #(.LARGE(LARGE)) u_sva (.clk(clk), .resetn(resetn), .ce(ce),
	.irq_take(irq_take), .data_we(data_we), .pc_r(pc_r), .prog_addr(prog_addr),
	.file_addr(file_addr), .data_rdata(data_rdata), .sfr_addr(sfr_addr),
	.status_r(status_r), .file_select_pointer_r(file_select_pointer_r));

// [tb/pdmm_core.sv]
`timescale 1ns/1ns
// ****
// Core operand access.
// ****
module pdmm_core (
	input  wire       clk,
	output reg  [6:0] file_addr = 7'h7f,
	output reg        data_rd = 1'b0,
	output reg        data_we = 1'b0,
	output reg  [7:0] data_wdata = 8'h00,
	input  wire [7:0] data_rdata
);
task acc(input [6:0] a, input w, input [7:0] d, output [7:0] q);
	begin
		@(posedge clk) #1;
		file_addr = a;
		data_rd = !w;
		data_we = w;
		data_wdata = d;
		@(posedge clk);
		q = data_rdata;
		#1;
		data_we = 1'b0;
		data_rd = 1'b0;
		data_wdata = ~d;
	end
endtask
endmodule

// [tb/program_data_memory_map_test.sv]
`timescale 1ns/1ns
// ****
// Bench.
// ****
module program_data_memory_map_test;
reg         clk = 0, resetn = 0, pc_load = 0, pc_inc = 0, irq_take = 0;
reg  [12:0] pc_load_val = 13'h0000;
reg         ce = 1;
reg  [7:0]  sfr_rdata = 8'h5a;
wire [7:0]  sfr_addr, status_r, file_select_pointer_r;
wire        sfr_sel;
wire [7:0]  data_rdata, data_wdata;
wire [6:0]  file_addr;
wire [12:0] pc_r;
wire [10:0] prog_addr;
wire        data_rd, data_we;
reg  [7:0]  q;
integer     fails = 0, cmp_count = 0;
always #2 clk = ~clk;
pdmm_map u_pdmm_map (.clk(clk), .resetn(resetn), .ce(ce), .pc_load(pc_load),
	.pc_load_val(pc_load_val), .pc_inc(pc_inc), .irq_take(irq_take), .pc_r(pc_r),
	.prog_addr(prog_addr), .file_addr(file_addr), .data_rd(data_rd), .data_we(data_we),
	.data_wdata(data_wdata), .data_rdata(data_rdata), .sfr_sel(sfr_sel),
	.sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .status_r(status_r),
	.file_select_pointer_r(file_select_pointer_r));
pdmm_core u_pdmm_core (.clk(clk), .file_addr(file_addr), .data_rd(data_rd),
	.data_we(data_we), .data_wdata(data_wdata), .data_rdata(data_rdata));
task chk(input [15:0] s, input [15:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			fails = fails + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	end
endtask
task print_verdict;
	begin
		$display("checks=%0d fails=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
endtask
task t_pc;
	begin
		chk(pc_r, 13'h0000);
		pc_load = 1;
		pc_load_val = 13'h1bfe;
		@(posedge clk) #1;
		pc_load = 0;
		pc_inc = 1;
		@(posedge clk) #1;
		pc_inc = 0;
		chk(pc_r, 13'h1bff);
		chk(prog_addr, 11'h3ff);
		irq_take = 1;
		@(posedge clk) #1;
		irq_take = 0;
		chk(pc_r, 13'h0004);
	end
endtask
task t_ram;
	begin
		u_pdmm_core.acc(7'h04, 1, 8'hf0, q);
		u_pdmm_core.acc(7'h00, 1, 8'ha5, q);
		u_pdmm_core.acc(7'h70, 0, 8'h00, q);
		chk(q, 8'ha5);
		u_pdmm_core.acc(7'h03, 1, 8'h38, q);
		u_pdmm_core.acc(7'h70, 0, 8'h00, q);
		chk(q, 8'ha5);
		u_pdmm_core.acc(7'h03, 1, 8'h18, q);
		u_pdmm_core.acc(7'h45, 1, 8'h3c, q);
		u_pdmm_core.acc(7'h25, 1, 8'hc3, q);
		u_pdmm_core.acc(7'h25, 0, 8'h00, q);
		chk(q, 8'h00);
		u_pdmm_core.acc(7'h45, 0, 8'h00, q);
		chk(q, 8'h3c);
	end
endtask
task t_sfr;
	begin
		u_pdmm_core.acc(7'h05, 0, 8'h00, q);
		chk(q, 8'h5a);
		chk(sfr_addr, 8'h05);
		chk(sfr_sel, 1'b0);
		chk(file_select_pointer_r, 8'hf0);
		chk(status_r, 8'h18);
		u_pdmm_core.acc(7'h03, 0, 8'h00, q);
		chk(q, 8'h18);
		ce = 0;
		pc_inc = 1;
		@(posedge clk) #1;
		pc_inc = 0;
		ce = 1;
		chk(pc_r, 13'h0004);
	end
endtask
initial begin
	repeat (10) @(posedge clk);
	#1 resetn = 1;
	t_pc;
	t_ram;
	t_sfr;
	print_verdict;
end
initial begin
	#4000 fails = fails + 1;
	print_verdict;
end
endmodule
